// file: rtl/msi_pkg.sv
`default_nettype none

package msi_pkg;

	// ==========================================
	// Timing.
	localparam int CLK_HZ          = 25000000;
	localparam int SLOW_FLASH_HZ   = 1;
	localparam int FAST_FLASH_HZ   = 2;
	localparam int SLOW_HALF_CYC   = CLK_HZ / (2 * SLOW_FLASH_HZ);
	localparam int FAST_HALF_CYC   = CLK_HZ / (2 * FAST_FLASH_HZ);

	// ==========================================
	// Session tracking.
	localparam int SESS_ID_W       = 4;
	localparam int SESS_LIMIT      = 8;
	localparam int SESS_CNT_W      = 5;

	// ==========================================
	// Lamp colours.
	typedef struct packed {
		logic red;
		logic green;
	} msi_lamp_t;

	localparam msi_lamp_t LAMP_OFF = 2'h0;

	// ==========================================
	// Inputs from the controller core.
	typedef struct packed {
		logic supply_bad;
		logic self_test;
		logic stopped;
		logic running;
		logic identify;
		logic cfg_invalid;
		logic err_local;
		logic err_remote;
	} msi_core_t;

	typedef enum logic [7:0] {
		ST_DARK     = 8'h01,
		ST_TEST     = 8'h02,
		ST_STOP     = 8'h04,
		ST_RUN      = 8'h08,
		ST_IDENT    = 8'h10,
		ST_CFG_BAD  = 8'h20,
		ST_ERR_LOC  = 8'h40,
		ST_ERR_REM  = 8'h80
	} msi_state_t;

endpackage

`default_nettype wire

// file: rtl/msi_lamp.sv
// Contract
// R1: Lamp is dark while supply voltage is out of range.
// R2: Self-test or initialising alternates red and green at 1 Hz.
// R3: Stop flashes green 1 Hz; run is steady green; start allowed from stop.
// R4: Identify request flashes green at 2 Hz.
// R5: Invalid configuration flashes red at 1 Hz.
// R6: Local serious error stops application, outputs off, red 2 Hz flash.
// R7: Remote serious error stops application, outputs off, steady red.
// R8: Only the most recently opened parallel session exchanges data.
// R9: Session overload with only keep-alive traffic forces serious error.
// R10: Write protection rejects every configuration change until released.
// R11: Flash patterns from clock, 50 percent duty, phase restarts on reset.
`timescale 1ns/100ps
`default_nettype none

module msi_lamp
	import msi_pkg::*;
#(
	parameter int SLOW_HALF = SLOW_HALF_CYC,
	parameter int FAST_HALF = FAST_HALF_CYC
)
(
	// Clock and reset.
	input  wire logic                 clock,
	input  wire logic                 srst,
	// Core state.
	input  wire msi_core_t            core,
	// Session events.
	input  wire logic                 sess_open,
	input  wire logic [SESS_ID_W-1:0] sess_open_id,
	input  wire logic                 sess_close,
	input  wire logic                 sess_data_seen,
	input  wire logic                 sess_keepalive,
	input  wire logic [SESS_ID_W-1:0] rx_sess_id,
	input  wire logic                 rx_valid,
	// Configuration writes.
	input  wire logic                 wp_set,
	input  wire logic                 wp_clear,
	input  wire logic                 cfg_wr_req,
	input  wire logic                 start_req,
	// Results.
	output var  msi_lamp_t            module_state_lamp,
	output logic                      rx_accept,
	output logic                      cfg_wr_grant,
	output logic                      cfg_wr_reject,
	output logic                      app_run,
	output logic                      outputs_enable,
	output logic                      overload_err,
	output logic                      wp_active,
	output logic [SESS_ID_W-1:0]      active_sess
);

	// ==========================================
	// Flash timebase.
	logic [24:0] slow_cnt;
	logic [24:0] fast_cnt;
	logic        slow_ph;
	logic        fast_ph;
	logic [24:0] next_slow_cnt;
	logic [24:0] next_fast_cnt;
	logic        next_slow_ph;
	logic        next_fast_ph;

	always_comb
	begin
		next_slow_cnt = slow_cnt + 25'h0000001;
		next_slow_ph  = slow_ph;
		next_fast_cnt = fast_cnt + 25'h0000001;
		next_fast_ph  = fast_ph;
		if (slow_cnt == 25'(SLOW_HALF - 1))
		begin
			next_slow_cnt = 25'h0000000;
			next_slow_ph  = ~slow_ph; // see R11
		end
		if (fast_cnt == 25'(FAST_HALF - 1))
		begin
			next_fast_cnt = 25'h0000000;
			next_fast_ph  = ~fast_ph; // see R11
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			slow_cnt <= 25'h0000000; // see R11
			fast_cnt <= 25'h0000000;
			slow_ph  <= 1'b1;
			fast_ph  <= 1'b1;
		end
		else
		begin
			slow_cnt <= next_slow_cnt;
			fast_cnt <= next_fast_cnt;
			slow_ph  <= next_slow_ph;
			fast_ph  <= next_fast_ph;
		end
	end

	// ==========================================
	// Session tracking and overload.
	logic [SESS_CNT_W-1:0] sess_cnt;
	logic [SESS_CNT_W-1:0] next_sess_cnt;
	logic [SESS_ID_W-1:0]  next_active_sess;
	logic                  next_overload_err;

	always_comb
	begin
		next_sess_cnt     = sess_cnt;
		next_active_sess  = active_sess;
		next_overload_err = overload_err;
		if (sess_open && !sess_close && sess_cnt != 5'h1F)
			next_sess_cnt = sess_cnt + 5'h01;
		else if (sess_close && !sess_open && sess_cnt != 5'h00)
			next_sess_cnt = sess_cnt - 5'h01;
		if (sess_open)
			next_active_sess = sess_open_id; // see R8
		if (sess_cnt >= 5'(SESS_LIMIT) && sess_keepalive && !sess_data_seen)
			next_overload_err = 1'b1; // see R9
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			sess_cnt     <= 5'h00;
			active_sess  <= 4'h0;
			overload_err <= 1'b0;
		end
		else
		begin
			sess_cnt     <= next_sess_cnt;
			active_sess  <= next_active_sess;
			overload_err <= next_overload_err;
		end
	end

	assign rx_accept = rx_valid && sess_cnt != 5'h00 && rx_sess_id == active_sess; // see R8

	// ==========================================
	// Write protection and application control.
	logic next_wp_active;
	logic next_app_run;
	logic serious;

	assign serious = core.err_local || core.err_remote || overload_err;

	always_comb
	begin
		next_wp_active = wp_active;
		if (wp_set)
			next_wp_active = 1'b1;
		else if (wp_clear)
			next_wp_active = 1'b0;
		next_app_run = app_run;
		if (serious)
			next_app_run = 1'b0; // see R6 R7
		else if (start_req && core.stopped && !core.supply_bad && !core.cfg_invalid)
			next_app_run = 1'b1; // see R3
		else if (!core.running)
			next_app_run = 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			wp_active <= 1'b0;
			app_run   <= 1'b0;
		end
		else
		begin
			wp_active <= next_wp_active;
			app_run   <= next_app_run;
		end
	end

	assign cfg_wr_grant   = cfg_wr_req && !wp_active;  // see R10
	assign cfg_wr_reject  = cfg_wr_req && wp_active;   // see R10
	assign outputs_enable = app_run && !serious;        // see R6 R7

	// ==========================================
	// Display state and lamp.
	msi_state_t disp;
	msi_lamp_t  next_lamp;

	always_comb
	begin
		if (core.supply_bad)
			disp = ST_DARK;
		else if (core.err_local || overload_err)
			disp = ST_ERR_LOC;
		else if (core.err_remote)
			disp = ST_ERR_REM;
		else if (core.cfg_invalid)
			disp = ST_CFG_BAD;
		else if (core.self_test)
			disp = ST_TEST;
		else if (core.identify)
			disp = ST_IDENT;
		else if (core.running)
			disp = ST_RUN;
		else
			disp = ST_STOP;
	end

	always_comb
	begin
		next_lamp = LAMP_OFF;
		case (disp)
			ST_DARK:    next_lamp = LAMP_OFF;                      // see R1
			ST_TEST:    next_lamp = {~slow_ph, slow_ph};           // see R2
			ST_STOP:    next_lamp = {1'b0, slow_ph};               // see R3
			ST_RUN:     next_lamp = {1'b0, 1'b1};                  // see R3
			ST_IDENT:   next_lamp = {1'b0, fast_ph};               // see R4
			ST_CFG_BAD: next_lamp = {slow_ph, 1'b0};               // see R5
			ST_ERR_LOC: next_lamp = {fast_ph, 1'b0};               // see R6
			ST_ERR_REM: next_lamp = {1'b1, 1'b0};                  // see R7
			default:    next_lamp = LAMP_OFF;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			module_state_lamp <= LAMP_OFF;
		else
			module_state_lamp <= next_lamp;
	end

	// ==========================================
	// Checks.
	property p_dark;
		@(posedge clock) disable iff (srst) core.supply_bad |=> module_state_lamp == LAMP_OFF;
	endproperty
	a_dark: assert property (p_dark) else $error("Lamp lit with supply bad."); // see R1

	property p_run_green;
		@(posedge clock) disable iff (srst)
		(core.running && !core.supply_bad && !serious && !core.cfg_invalid
		&& !core.self_test && !core.identify) |=> module_state_lamp == 2'h1;
	endproperty
	a_run_green: assert property (p_run_green) else $error("Run not steady green."); // see R3

	property p_remote_red;
		@(posedge clock) disable iff (srst)
		(core.err_remote && !core.err_local && !overload_err && !core.supply_bad)
		|=> module_state_lamp == 2'h2;
	endproperty
	a_remote_red: assert property (p_remote_red) else $error("Remote error not red."); // see R7

	property p_err_outputs;
		@(posedge clock) disable iff (srst) serious |-> !outputs_enable ##1 !app_run;
	endproperty
	a_err_outputs: assert property (p_err_outputs) else $error("Outputs on in error."); // see R6

	property p_local_green_off;
		@(posedge clock) disable iff (srst)
		(core.err_local && !core.supply_bad) |=> !module_state_lamp.green;
	endproperty
	a_local_green_off: assert property (p_local_green_off) else $error("Green in local error."); // see R6

	property p_latest;
		@(posedge clock) disable iff (srst)
		sess_open |=> active_sess == $past(sess_open_id);
	endproperty
	a_latest: assert property (p_latest) else $error("Latest session not active."); // see R8

	property p_overload;
		@(posedge clock) disable iff (srst)
		(sess_cnt >= 5'(SESS_LIMIT) && sess_keepalive && !sess_data_seen) |=> overload_err;
	endproperty
	a_overload: assert property (p_overload) else $error("Overload not flagged."); // see R9

	property p_wp;
		@(posedge clock) disable iff (srst) (cfg_wr_req && $past(wp_set)) |-> cfg_wr_reject && !cfg_wr_grant;
	endproperty
	a_wp: assert property (p_wp) else $error("Write granted while protected."); // see R10

	property p_slow_duty;
		@(posedge clock) disable iff (srst)
		(slow_cnt == 25'(SLOW_HALF - 1)) |=> slow_ph != $past(slow_ph) ##1 slow_ph == $past(slow_ph);
	endproperty
	a_slow_duty: assert property (p_slow_duty) else $error("Slow phase toggle wrong."); // see R11

	property p_test_alt;
		@(posedge clock) disable iff (srst)
		(disp == ST_TEST) |=> module_state_lamp.red != module_state_lamp.green;
	endproperty
	a_test_alt: assert property (p_test_alt) else $error("Self-test not alternating."); // see R2

endmodule

`default_nettype wire

// file: verification/msi_lamp_tb.sv
`timescale 1ns/100ps
`default_nettype none

module msi_lamp_tb
	import msi_pkg::*;
;
	// ==========================================
	// Stimulus and results.
	localparam int SH = 10;
	localparam int FH = 5;
	logic                 clock = 1'b0;
	logic                 srst = 1'b1;
	msi_core_t            core = 8'h40;
	logic                 so = 1'b0, sd = 1'b0, sk = 1'b0, rv = 1'b0, sc = 1'b0;
	logic                 ws = 1'b0, wc = 1'b0, wr = 1'b0, st = 1'b0;
	logic [SESS_ID_W-1:0] oid = 4'h0, rid = 4'h0, act;
	msi_lamp_t            lamp;
	logic                 acc, gr, rj, app, oe, ov, wp;
	int                   fails = 0;
	int                   cmp_count = 0;

	always #20 clock = ~clock;

	msi_lamp #(.SLOW_HALF(SH), .FAST_HALF(FH)) u_dut (.clock(clock), .srst(srst),
		.core(core), .sess_open(so), .sess_open_id(oid), .sess_close(sc),
		.sess_data_seen(sd), .sess_keepalive(sk), .rx_sess_id(rid), .rx_valid(rv),
		.wp_set(ws), .wp_clear(wc), .cfg_wr_req(wr), .start_req(st),
		.module_state_lamp(lamp), .rx_accept(acc), .cfg_wr_grant(gr),
		.cfg_wr_reject(rj), .app_run(app), .outputs_enable(oe), .overload_err(ov),
		.wp_active(wp), .active_sess(act));

	// ==========================================
	// Shared tasks.
	task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic do_reset;
		@(posedge clock);
		srst <= 1'b1;
		repeat (4) @(posedge clock);
		@(negedge clock);
		cmp({lamp, app, ov, wp, act}, 9'h000);
		@(posedge clock);
		srst <= 1'b0;
	endtask

	// Counts red, green, both lit and edges of each colour over n cycles.
	task automatic measure(input int n, output logic [39:0] r);
		msi_lamp_t prev;
		int        cr, cg, er, eg, bt;
		cr = 0;
		cg = 0;
		er = 0;
		eg = 0;
		bt = 0;
		@(negedge clock);
		prev = lamp;
		repeat (n)
		begin
			@(negedge clock);
			if (prev.red === 1'b1)
				cr++;
			if (prev.green === 1'b1)
				cg++;
			if (prev.red === 1'b1 && prev.green === 1'b1)
				bt++;
			if (lamp.red !== prev.red)
				er++;
			if (lamp.green !== prev.green)
				eg++;
			prev = lamp;
		end
		r = {cr[7:0], cg[7:0], er[7:0], eg[7:0], bt[7:0]};
	endtask

	task automatic open_sess(input logic [SESS_ID_W-1:0] id);
		@(posedge clock);
		so <= 1'b1;
		oid <= id;
		@(posedge clock);
		so <= 1'b0;
	endtask

	task automatic keep_alive(input logic d, input logic exp);
		@(posedge clock);
		sk <= 1'b1;
		sd <= d;
		@(posedge clock);
		sk <= 1'b0;
		sd <= 1'b0;
		@(negedge clock);
		cmp(ov, exp);
	endtask

	// ==========================================
	// Scenarios.
	task automatic t_phase;
		repeat (3) @(posedge clock);
		@(negedge clock);
		cmp(lamp, 2'h1);
	endtask

	task automatic t_lamp;
		logic [7:0]  cv [8] = '{8'hFF, 8'h7F, 8'h7D, 8'h7C, 8'h78, 8'h38, 8'h30, 8'h20};
		logic [39:0] ex [8] = '{40'h0, 40'h0A00040000, 40'h1400000000, 40'h0A00020000,
			40'h0A0A020200, 40'h000A000400, 40'h0014000000, 40'h000A000200};
		logic [39:0] got;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clock);
			core <= cv[i];
			repeat (3) @(posedge clock);
			measure(2 * SH, got);
			cmp(got, ex[i]);
		end
	endtask

	task automatic t_wp;
		@(posedge clock);
		wr <= 1'b1;
		@(negedge clock);
		cmp({gr, rj}, 2'b10);
		@(posedge clock);
		ws <= 1'b1;
		@(posedge clock);
		ws <= 1'b0;
		@(negedge clock);
		cmp({wp, gr, rj}, 3'b101);
		@(posedge clock);
		wc <= 1'b1;
		ws <= 1'b1;
		@(posedge clock);
		ws <= 1'b0;
		@(negedge clock);
		cmp({wp, gr, rj}, 3'b101);
		@(posedge clock);
		wc <= 1'b0;
		@(negedge clock);
		cmp({wp, gr, rj}, 3'b010);
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic t_start;
		@(posedge clock);
		core <= 8'h24;
		st <= 1'b1;
		@(posedge clock);
		st <= 1'b0;
		core <= 8'h20;
		@(negedge clock);
		cmp(app, 1'b0);
		@(posedge clock);
		st <= 1'b1;
		@(posedge clock);
		st <= 1'b0;
		core <= 8'h10;
		@(negedge clock);
		cmp({app, oe}, 2'b11);
		@(posedge clock);
		core <= 8'h11;
		@(negedge clock);
		cmp(oe, 1'b0);
		@(negedge clock);
		cmp({app, oe}, 2'b00);
	endtask

	task automatic t_sess;
		logic [39:0] got;
		@(posedge clock);
		core <= 8'h20;
		st <= 1'b1;
		rv <= 1'b1;
		@(posedge clock);
		st <= 1'b0;
		core <= 8'h10;
		@(negedge clock);
		cmp({acc, app}, 2'b01);
		open_sess(4'h3);
		open_sess(4'h7);
		@(posedge clock);
		rid <= 4'h3;
		@(negedge clock);
		cmp({acc, act}, 5'h07);
		@(posedge clock);
		rid <= 4'h7;
		@(negedge clock);
		cmp(acc, 1'b1);
		@(posedge clock);
		sc <= 1'b1;
		repeat (2) @(posedge clock);
		sc <= 1'b0;
		@(negedge clock);
		cmp(acc, 1'b0);
		@(posedge clock);
		rv <= 1'b0;
		for (int i = 0; i < 7; i++)
			open_sess(4'(i));
		keep_alive(1'b0, 1'b0);
		open_sess(4'hC);
		keep_alive(1'b1, 1'b0);
		keep_alive(1'b0, 1'b1);
		cmp(oe, 1'b0);
		measure(2 * SH, got);
		cmp(got, 40'h0A00040000);
		cmp({app, oe}, 2'b00);
	endtask

	// ==========================================
	// Sequence and watchdog.
	initial
	begin
		do_reset();
		t_phase();
		t_lamp();
		t_wp();
		t_start();
		do_reset();
		t_sess();
		print_verdict();
	end

	initial
	begin
		#(40 * 5000);
		fails++;
		print_verdict();
	end

endmodule

`default_nettype wire
